// ==== hdl/rcsp_parser.v ====
// Remote command and source route request parser with AXI4-Lite registers
`timescale 1ns/1ps
`include "rcsp_defs.vh"

// Notes on behaviour
// - A frame whose type byte at offset 3 is 0x17 is decoded as a remote parameter request.
// - The request tag at offset 4 is kept and a zero tag means no response is owed.
// - Offsets 5 to 12 give the 64-bit target address, most significant byte first.
// - An all-zero 64-bit target address is flagged as the network coordinator.
// - Options bit 0x01 suppresses acknowledgement and bit 0x40 selects the extended timeout.
// - Option bit 0x02 asks the remote node to apply changes, else an apply_changes_command.
// - Offsets 16-17 hold the two ASCII characters naming the target parameter.
// - Bytes from offset 18 on are the value, and with none the request is a read query.
// - A frame of type 0x21 creates a source route and never owes a response.
// - A badly formed route frame is dropped, pulsing frame_drop and adding one to the drop count in STATUS.
// - A hop count at offset 16 of zero or above the table size of 40 drops the frame.
// - A hop count above 11 also drops the frame.
// - Hop addresses follow from offset 17 as two-byte words, destination neighbour first.
module rcsp_parser #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        s_valid,
  output wire        s_ready,
  input  wire [7:0]  s_data,
  input  wire        s_last,
  input  wire        s_good,
  output wire        result_pending,
  output reg         frame_drop,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  wire        f_valid;
  wire        f_ready;
  wire [9:0]  f_word;
  wire [7:0]  b_data;
  wire        b_last;
  wire        b_good;
  wire        take;

  rcsp_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .in_data   ({s_good, s_last, s_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word)
  );

  assign b_data = f_word[7:0];
  assign b_last = f_word[8];
  assign b_good = f_word[9];

  // ****************************************************************
  // Decode state
  // ****************************************************************
  reg         enable_reg;
  reg         pending_reg;
  reg         ack_req;
  reg  [7:0]  idx_reg;
  reg  [7:0]  type_reg;
  reg  [7:0]  tag_reg;
  reg  [63:0] dest_reg;
  reg  [15:0] short_reg;
  reg  [7:0]  opt_reg;
  reg  [15:0] cmd_reg;
  reg  [7:0]  plen_reg;
  reg  [31:0] param_reg;
  reg  [7:0]  hops_reg;
  reg  [7:0]  hbytes_reg;
  reg  [31:0] hopw_reg;
  reg  [7:0]  drops_reg;
  reg         kind_reg;
  reg         respond_reg;
  reg         query_reg;
  reg         coord_reg;
  wire        is_remote;
  wire        is_route;
  wire        hops_ok;
  wire        frame_ok;

  // Stall while a decoded result waits for software
  assign f_ready        = !pending_reg;
  assign take           = f_valid && f_ready;
  assign result_pending = pending_reg;

  assign is_remote = (type_reg == `RCSP_TYPE_REMOTE);
  assign is_route  = (type_reg == `RCSP_TYPE_ROUTE);
  assign hops_ok   = (hops_reg != 8'h00) && (hops_reg <= `RCSP_ROUTE_TABLE)
                     && (hops_reg <= `RCSP_MAX_HOPS);
  assign frame_ok  = enable_reg && b_good && (idx_reg >= `RCSP_OFS_CMD_LAST)
                     && (is_remote || (is_route && hops_ok
                     && (idx_reg == `RCSP_OFS_HOPS + {hops_reg[6:0], 1'b0})));

  always @(posedge aclk) begin
    if (!aresetn) begin
      idx_reg     <= `RCSP_OFS_TYPE;
      type_reg    <= 8'h00;
      tag_reg     <= 8'h00;
      dest_reg    <= 64'h0000_0000_0000_0000;
      short_reg   <= 16'h0000;
      opt_reg     <= 8'h00;
      cmd_reg     <= 16'h0000;
      plen_reg    <= 8'h00;
      param_reg   <= 32'h0000_0000;
      hops_reg    <= 8'h00;
      hbytes_reg  <= 8'h00;
      hopw_reg    <= 32'h0000_0000;
      drops_reg   <= 8'h00;
      kind_reg    <= 1'b0;
      respond_reg <= 1'b0;
      query_reg   <= 1'b0;
      coord_reg   <= 1'b0;
      pending_reg <= 1'b0;
      frame_drop  <= 1'b0;
    end else begin
      frame_drop <= 1'b0;
      if (take) begin
        if (idx_reg != `RCSP_OFS_MAX) begin
          idx_reg <= idx_reg + 8'h01;
        end
        if (idx_reg == `RCSP_OFS_TYPE) begin
          type_reg   <= b_data;
          plen_reg   <= 8'h00;
          param_reg  <= 32'h0000_0000;
          hbytes_reg <= 8'h00;
          hopw_reg   <= 32'h0000_0000;
        end
        if (idx_reg == `RCSP_OFS_TAG) begin
          tag_reg <= b_data;
        end
        if ((idx_reg >= `RCSP_OFS_DEST_FIRST) && (idx_reg <= `RCSP_OFS_DEST_LAST)) begin
          dest_reg <= {dest_reg[55:0], b_data};
        end
        if ((idx_reg >= `RCSP_OFS_SHORT_FIRST) && (idx_reg <= `RCSP_OFS_SHORT_LAST)) begin
          short_reg <= {short_reg[7:0], b_data};
        end
        if (idx_reg == `RCSP_OFS_OPTIONS) begin
          opt_reg <= b_data;
        end
        if (is_remote && (idx_reg >= `RCSP_OFS_CMD_FIRST) && (idx_reg <= `RCSP_OFS_CMD_LAST)) begin
          cmd_reg <= {cmd_reg[7:0], b_data};
        end
        if (is_remote && (idx_reg >= `RCSP_OFS_PARAM)) begin
          if (plen_reg != `RCSP_OFS_MAX) begin
            plen_reg <= plen_reg + 8'h01;
          end
          if (plen_reg < 8'h04) begin
            param_reg <= {param_reg[23:0], b_data};
          end
        end
        if (is_route && (idx_reg == `RCSP_OFS_HOPS)) begin
          hops_reg <= b_data;
        end
        if (is_route && (idx_reg >= `RCSP_OFS_HOP_ADDR)) begin
          if (hbytes_reg != `RCSP_OFS_MAX) begin
            hbytes_reg <= hbytes_reg + 8'h01;
          end
          if (hbytes_reg < 8'h04) begin
            hopw_reg <= {hopw_reg[23:0], b_data};
          end
        end
        if (b_last) begin
          idx_reg <= `RCSP_OFS_TYPE;
          if (frame_ok) begin
            pending_reg <= 1'b1;
            kind_reg    <= is_route;
            respond_reg <= is_remote && (tag_reg != 8'h00);
            query_reg   <= is_remote && (idx_reg < `RCSP_OFS_PARAM);
            coord_reg   <= (dest_reg == 64'h0000_0000_0000_0000);
          end else begin
            frame_drop <= 1'b1;
            drops_reg  <= drops_reg + 8'h01;
          end
        end
      end else if (ack_req) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite register slave
  // ****************************************************************
  reg         aw_have;
  reg         w_have;
  reg  [5:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  wire        do_write;

  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_have && w_have && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_addr      <= 6'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RCSP_RESP_OKAY;
      enable_reg   <= `RCSP_CTRL_RESET;
      ack_req      <= 1'b0;
    end else begin
      ack_req <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({aw_addr[5:2], 2'b00} == `RCSP_REG_CTRL) begin
          s_axi_bresp <= `RCSP_RESP_OKAY;
          if (w_strb[0]) begin
            enable_reg <= w_data[`RCSP_CTRL_ENABLE];
            ack_req    <= w_data[`RCSP_CTRL_ACK];
          end
        end else begin
          s_axi_bresp <= `RCSP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `RCSP_REG_CTRL:     rd_mux = {31'h0000_0000, enable_reg};
      `RCSP_REG_STATUS:   rd_mux = {8'h00, drops_reg, tag_reg, opt_reg[`RCSP_OPT_APPLY],
                                    opt_reg[`RCSP_OPT_EXT_TIMEOUT], opt_reg[`RCSP_OPT_NO_ACK],
                                    coord_reg, query_reg, respond_reg, kind_reg, pending_reg};
      `RCSP_REG_DEST_HI:  rd_mux = dest_reg[63:32];
      `RCSP_REG_DEST_LO:  rd_mux = dest_reg[31:0];
      `RCSP_REG_ADDR_CMD: rd_mux = {cmd_reg, short_reg};
      `RCSP_REG_LENGTHS:  rd_mux = {8'h00, hbytes_reg, hops_reg, plen_reg};
      `RCSP_REG_PARAM:    rd_mux = param_reg;
      `RCSP_REG_HOPS:     rd_mux = hopw_reg;
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RCSP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `RCSP_RESP_OKAY : `RCSP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rcsp_parser

// ==== hdl/rcsp_defs.vh ====
// Constants for the remote command and source route parser
`ifndef RCSP_DEFS_VH
`define RCSP_DEFS_VH

// ****************************************************************
// Frame types and byte offsets
// ****************************************************************
`define RCSP_TYPE_REMOTE     8'h17
`define RCSP_TYPE_ROUTE      8'h21
`define RCSP_OFS_TYPE        8'h03
`define RCSP_OFS_TAG         8'h04
`define RCSP_OFS_DEST_FIRST  8'h05
`define RCSP_OFS_DEST_LAST   8'h0C
`define RCSP_OFS_SHORT_FIRST 8'h0D
`define RCSP_OFS_SHORT_LAST  8'h0E
`define RCSP_OFS_OPTIONS     8'h0F
`define RCSP_OFS_CMD_FIRST   8'h10
`define RCSP_OFS_CMD_LAST    8'h11
`define RCSP_OFS_PARAM       8'h12
`define RCSP_OFS_HOPS        8'h10
`define RCSP_OFS_HOP_ADDR    8'h11
`define RCSP_OFS_MAX         8'hFF

// ****************************************************************
// Option bits and hop limits
// ****************************************************************
`define RCSP_OPT_NO_ACK      0
`define RCSP_OPT_APPLY       1
`define RCSP_OPT_EXT_TIMEOUT 6
`define RCSP_ROUTE_TABLE     8'h28
`define RCSP_MAX_HOPS        8'h0B

// ****************************************************************
// Register map
// ****************************************************************
`define RCSP_REG_CTRL        6'h00
`define RCSP_REG_STATUS      6'h04
`define RCSP_REG_DEST_HI     6'h08
`define RCSP_REG_DEST_LO     6'h0C
`define RCSP_REG_ADDR_CMD    6'h10
`define RCSP_REG_LENGTHS     6'h14
`define RCSP_REG_PARAM       6'h18
`define RCSP_REG_HOPS        6'h1C
`define RCSP_CTRL_ENABLE     0
`define RCSP_CTRL_ACK        1
`define RCSP_CTRL_RESET      1'b1
`define RCSP_RESP_OKAY       2'b00
`define RCSP_RESP_SLVERR     2'b10

`endif

// ==== hdl/rcsp_fifo.v ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps

module rcsp_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // rcsp_fifo

// ==== verification/rcsp_parser_chk.sv ====
// Assertion checker for the remote command and source route parser
`timescale 1ns/1ps
`include "rcsp_defs.vh"

module rcsp_parser_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_valid,
  input wire        s_ready,
  input wire [7:0]  s_data,
  input wire        s_last,
  input wire        s_good,
  input wire        result_pending,
  input wire        frame_drop,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [5:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_drop_pulse: assert property (frame_drop |=> !frame_drop)
    else $error("drop pulse longer than one cycle");
  chk_drop_nopend: assert property (frame_drop |-> !result_pending)
    else $error("drop while a result is pending");
  chk_pend_ack: assert property ($fell(result_pending) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pending cleared without a write");
  chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  chk_rd_unmap: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5]
    |=> s_axi_rresp == `RCSP_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_wr_ro: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[5:2] != 4'h0 |-> ##2 s_axi_bvalid && s_axi_bresp == `RCSP_RESP_SLVERR)
    else $error("read-only write not refused");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
endmodule // rcsp_parser_chk

bind rcsp_parser rcsp_parser_chk chk_i (.aclk(aclk), .aresetn(aresetn), .s_valid(s_valid),
  .s_ready(s_ready), .s_data(s_data), .s_last(s_last), .s_good(s_good),
  .result_pending(result_pending), .frame_drop(frame_drop), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// ==== verification/rcsp_host.sv ====
// Host model that feeds frame bytes to the parser stream input
`timescale 1ns/1ps

module rcsp_host (
  input  wire       aclk,
  input  wire       s_ready,
  output reg        s_valid,
  output reg  [7:0] s_data,
  output reg        s_last,
  output reg        s_good
);
  reg [7:0] fbuf [0:127];
  reg       ok;
  integer   i;

  initial begin
    s_valid = 1'b0;
    s_data  = 8'h00;
    s_last  = 1'b0;
    s_good  = 1'b0;
  end

  // Bytes back to back, each held until taken
  task send(input integer n, input g);
    begin
      for (i = 0; i < n; i = i + 1) begin
        s_valid <= 1'b1;
        s_data  <= fbuf[i];
        s_last  <= (i == n - 1);
        s_good  <= g && (i == n - 1);
        ok = 1'b0;
        while (!ok) begin
          @(negedge aclk);
          ok = s_ready;
          @(posedge aclk);
        end
      end
      s_valid <= 1'b0;
      s_last  <= 1'b0;
      s_good  <= 1'b0;
      s_data  <= ~fbuf[n - 1];
    end
  endtask
endmodule // rcsp_host

// ==== verification/rcsp_parser_test.sv ====
// Self-checking bench for the remote command and source route parser
`timescale 1ns/1ps
`include "rcsp_defs.vh"

module rcsp_parser_test;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [5:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd, rb, pv;
  reg  [3:0]  s_axi_wstrb;
  reg  [1:0]  rr;
  reg  [63:0] dst;
  reg  [7:0]  tg, op;
  wire        s_valid, s_ready, s_last, s_good, result_pending, frame_drop;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [7:0]  s_data;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     miscompares, n_checks, j, k, n, ndrop;

  rcsp_parser uut (.aclk(aclk), .aresetn(aresetn), .s_valid(s_valid), .s_ready(s_ready),
    .s_data(s_data), .s_last(s_last), .s_good(s_good), .result_pending(result_pending),
    .frame_drop(frame_drop), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  rcsp_host host (.aclk(aclk), .s_ready(s_ready), .s_valid(s_valid), .s_data(s_data),
    .s_last(s_last), .s_good(s_good));

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        miscompares = miscompares + 1;
      end
    end
  endtask

  task axi_wr(input [5:0] a, input [31:0] d, input [1:0] er);
    reg ta, tw, tb;
    begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
        @(negedge aclk);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid;
        rr = s_axi_bresp;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
      chk(rr, er);
    end
  endtask

  task axi_rd(input [5:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
    reg ta, tr;
    begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
        @(negedge aclk);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      chk(rd & m, e);
      chk(rr, er);
    end
  endtask

  task ack;
    begin
      axi_wr(`RCSP_REG_CTRL, 32'h0000_0003, `RCSP_RESP_OKAY);
      chk(result_pending, 1'b0);
    end
  endtask

  task wait_out(input ep);
    integer c;
    reg p, f;
    begin
      p = 1'b0;
      f = 1'b0;
      for (c = 0; c < 200 && !p && !f; c = c + 1) begin
        @(negedge aclk);
        p = result_pending === 1'b1;
        f = frame_drop === 1'b1;
        @(posedge aclk);
      end
      chk(p, ep);
      chk(f, !ep);
    end
  endtask

  // Random fill from offset 5 on, then the fixed fields; pv keeps the first four value bytes
  task mk_frame(input [7:0] ty, input [7:0] t, input [7:0] o, input integer first, input integer nb);
    integer i;
    begin
      for (i = 2; i < 128; i = i + 1) begin
        rb = $urandom;
        host.fbuf[i] = rb[7:0];
      end
      host.fbuf[0] = ty;
      host.fbuf[1] = t;
      host.fbuf[12] = o;
      pv = 32'h0000_0000;
      for (i = 0; i < nb && i < 4; i = i + 1) pv = {pv[23:0], host.fbuf[first + i]};
    end
  endtask

  task mk_remote(input integer np);
    integer i;
    begin
      mk_frame(`RCSP_TYPE_REMOTE, tg, op, 15, np);
      for (i = 0; i < 8; i = i + 1) host.fbuf[2 + i] = dst[63 - 8 * i -: 8];
      host.fbuf[10] = 8'hFF;
      host.fbuf[11] = 8'hFE;
      host.fbuf[13] = 8'h42;
      host.fbuf[14] = 8'h48;
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    miscompares = miscompares + 1;
    results;
  end

  initial begin
    miscompares = 0;
    n_checks = 0;
    ndrop = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    rb = $urandom(72);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`RCSP_REG_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
    axi_rd(`RCSP_REG_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
    axi_rd(6'h20, 32'h0000_0000, 32'hFFFF_FFFF, `RCSP_RESP_SLVERR);
    axi_wr(`RCSP_REG_STATUS, 32'hFFFF_FFFF, `RCSP_RESP_SLVERR);
    // Remote requests: each option value, zero tag, coordinator, query; later ones fill the FIFO
    for (j = 0; j < 4; j = j + 1) begin
      rb = $urandom;
      tg = (j == 1) ? 8'h00 : {1'b1, rb[6:0]};
      dst = (j == 2) ? 64'h0000_0000_0000_0000 : {$urandom, $urandom};
      pv = 32'h0140_0201 >> (8 * j);
      op = pv[7:0];
      n = (j == 3) ? 0 : 2 * j + 1;
      mk_remote(n);
      if (j == 0) host.send(15 + n, 1'b1);
      else fork
        host.send(15 + n, 1'b1);
        begin
          repeat (12) @(posedge aclk);
          chk(s_ready, 1'b0);
          ack;
        end
      join
      wait_out(1'b1);
      rb = {16'h0000, tg, op[1], op[6], op[0], dst == 64'h0, n == 0, tg != 8'h00, 2'b01};
      axi_rd(`RCSP_REG_STATUS, rb, 32'h00FF_FFFF, `RCSP_RESP_OKAY);
      axi_rd(`RCSP_REG_DEST_HI, dst[63:32], 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
      axi_rd(`RCSP_REG_DEST_LO, dst[31:0], 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
      axi_rd(`RCSP_REG_ADDR_CMD, 32'h4248_FFFE, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
      axi_rd(`RCSP_REG_PARAM, pv, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
      axi_rd(`RCSP_REG_LENGTHS, n, 32'h0000_00FF, `RCSP_RESP_OKAY);
    end
    ack;
    // Route requests over hop counts at and beyond the limits, last one a byte too long
    for (j = 0; j < 8; j = j + 1) begin
      dst = 64'h0103_0B00_0C28_2903 >> (56 - 8 * j);
      k = dst[7:0];
      mk_frame(`RCSP_TYPE_ROUTE, 8'h00, 8'h00, 14, 2 * k);
      host.fbuf[13] = dst[7:0];
      host.send(14 + 2 * k + (j == 7), 1'b1);
      if (k >= 1 && k <= 11 && j != 7) begin
        wait_out(1'b1);
        axi_rd(`RCSP_REG_STATUS, 32'h0000_0003, 32'h0000_0007, `RCSP_RESP_OKAY);
        axi_rd(`RCSP_REG_HOPS, pv, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
        rb = k * 32'h0002_0100;
        axi_rd(`RCSP_REG_LENGTHS, rb, 32'hFFFF_FFFF, `RCSP_RESP_OKAY);
        ack;
      end else begin
        wait_out(1'b0);
        ndrop = ndrop + 1;
      end
    end
    // Bad checksum, unknown type and a disabled parser all drop the frame
    mk_remote(1);
    host.send(16, 1'b0);
    wait_out(1'b0);
    host.fbuf[0] = 8'h08;
    host.send(16, 1'b1);
    wait_out(1'b0);
    axi_wr(`RCSP_REG_CTRL, 32'h0000_0000, `RCSP_RESP_OKAY);
    mk_remote(1);
    host.send(16, 1'b1);
    wait_out(1'b0);
    axi_wr(`RCSP_REG_CTRL, 32'h0000_0001, `RCSP_RESP_OKAY);
    ndrop = ndrop + 3;
    axi_rd(`RCSP_REG_STATUS, ndrop << 16, 32'h00FF_0001, `RCSP_RESP_OKAY);
    results;
  end
endmodule // rcsp_parser_test
